// File: rtl/aacs_amp.sv
// aacs_amp: amplifier-side control/status register bank with clock auto-detection
// assumes host signals are on ref_clk; mclk/sclk/lrclk and fault lines are asynchronous
`timescale 1ns/1ps
module aacs_amp
  import aacs_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // link
  aacs_if.amp link,
  // controls toward the datapath
  output logic dc_block_en,
  output logic hard_unmute,
  output logic [1:0] deemph_sel,
  output logic [3:0] audio_format,
  output logic all_shutdown,
  output logic [1:0] quiet_ch,
  // audio stream status
  output logic [2:0] sample_frequency,
  output logic [2:0] mclk_ratio,
  output logic pll_locked
);
  // counter must hold the slowest frame
  if (CNT_W < 15 || CNT_W > 24) begin : g_bad_cnt_w
    $error("aacs_amp: CNT_W out of range");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] s1_q, s2_q, s3_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else if (clk_en) begin
      s1_q <= {link.temp_warn, link.prot_fault, link.lrclk, link.sclk, link.mclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire mclk_rise = s2_q[0] & ~s3_q[0];
  wire sclk_rise = s2_q[1] & ~s3_q[1];
  wire lr_rise = s2_q[2] & ~s3_q[2];

  // ****************************************
  // per-frame counting
  // ****************************************
  logic [CNT_W-1:0] ref_cnt_q, ref_last_q;
  logic [9:0] mclk_cnt_q, mclk_last_q;
  logic [7:0] sclk_cnt_q, sclk_last_q;
  logic [1:0] frames_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_q <= '0;
      ref_last_q <= '0;
      mclk_cnt_q <= 10'h000;
      mclk_last_q <= 10'h000;
      sclk_cnt_q <= 8'h00;
      sclk_last_q <= 8'h00;
      frames_q <= 2'h0;
    end else if (clk_en) begin
      if (lr_rise) begin
        ref_cnt_q <= '0;
        ref_last_q <= ref_cnt_q;
        mclk_cnt_q <= 10'h000;
        mclk_last_q <= mclk_cnt_q;
        sclk_cnt_q <= 8'h00;
        sclk_last_q <= sclk_cnt_q;
        if (frames_q != 2'h3) frames_q <= frames_q + 2'h1;
      end else begin
        if (ref_cnt_q != '1) ref_cnt_q <= ref_cnt_q + 1'b1;
        if (mclk_rise && mclk_cnt_q != 10'h3ff) mclk_cnt_q <= mclk_cnt_q + 10'h001;
        if (sclk_rise && sclk_cnt_q != 8'hff) sclk_cnt_q <= sclk_cnt_q + 8'h01;
      end
    end
  end

  function automatic logic [2:0] rate_code(input logic [CNT_W-1:0] cyc);
    int c;
    c = int'(cyc);
    if (c < (FRAME_CYC_48K + FRAME_CYC_32K) / 2) rate_code = RATE_48K;
    else if (c < (FRAME_CYC_32K + FRAME_CYC_24K) / 2) rate_code = RATE_32K;
    else if (c < (FRAME_CYC_24K + FRAME_CYC_16K) / 2) rate_code = RATE_24K;
    else if (c < (FRAME_CYC_16K + FRAME_CYC_12K) / 2) rate_code = RATE_16K;
    else if (c < (FRAME_CYC_12K + FRAME_CYC_8K) / 2) rate_code = RATE_12K;
    else rate_code = RATE_8K;
  endfunction

  function automatic logic [2:0] ratio_code(input logic [9:0] n);
    case (n)
      10'd64: ratio_code = RATIO_64;
      10'd128: ratio_code = RATIO_128;
      10'd192: ratio_code = RATIO_192;
      10'd256: ratio_code = RATIO_256;
      10'd384: ratio_code = RATIO_384;
      10'd512: ratio_code = RATIO_512;
      default: ratio_code = RATIO_BAD;
    endcase
  endfunction

  function automatic logic differs(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    differs = (a > b) ? (a - b > CNT_W'(FRAME_TOL)) : (b - a > CNT_W'(FRAME_TOL));
  endfunction

  // ****************************************
  // detection and fault events
  // ****************************************
  wire judge = lr_rise && frames_q == 2'h3;
  wire ev_mclk = judge && mclk_cnt_q != mclk_last_q;
  wire ev_sclk = judge && sclk_cnt_q != sclk_last_q;
  wire ev_lr = judge && rate_code(ref_cnt_q) != rate_code(ref_last_q);
  wire ev_slip = judge && !ev_lr && differs(ref_cnt_q, ref_last_q);
  wire ev_pll = judge && ratio_code(mclk_cnt_q) == RATIO_BAD;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_frequency <= RATE_48K;
      mclk_ratio <= RATIO_256;
      pll_locked <= 1'b0;
    end else if (clk_en && judge) begin
      sample_frequency <= rate_code(ref_cnt_q);
      mclk_ratio <= ratio_code(mclk_cnt_q);
      pll_locked <= !ev_pll;
    end
  end

  // ****************************************
  // register bank
  // ****************************************
  logic [7:0] faults_q, ctrl1_q, format_q, shut_q, quiet_q, rdata_q;
  wire [7:0] events = {ev_mclk, ev_pll, ev_sclk, ev_lr, ev_slip, 1'b0, s3_q[3], s3_q[4]};
  wire fault_wr = link.wr && link.addr == ADDR_FAULTS;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      faults_q <= RST_FAULTS;
    end else if (clk_en) begin
      // set wins over a write of zero in the same cycle
      faults_q <= (fault_wr ? (faults_q & link.wdata) : faults_q) | events;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q <= RST_CTRL1;
      format_q <= RST_FORMAT;
      shut_q <= RST_SHUTDOWN;
      quiet_q <= RST_QUIET;
    end else if (clk_en && link.wr) begin
      // status and id writes fall through
      if (link.addr == ADDR_CTRL1) begin
        ctrl1_q <= link.wdata & CTRL1_MASK;
      end else if (link.addr == ADDR_FORMAT) begin
        format_q <= link.wdata & FORMAT_MASK;
      end else if (link.addr == ADDR_SHUTDOWN) begin
        shut_q <= link.wdata & SHUTDOWN_MASK;
      end else if (link.addr == ADDR_QUIET) begin
        quiet_q <= link.wdata & QUIET_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (!link.rd) begin
        rdata_q <= 8'h00;
      end else if (link.addr == ADDR_CLK_STATUS) begin
        rdata_q <= {sample_frequency, mclk_ratio, 2'b00};
      end else if (link.addr == ADDR_FW_ID) begin
        rdata_q <= {1'b0, FW_ID_VALUE};
      end else if (link.addr == ADDR_FAULTS) begin
        rdata_q <= faults_q;
      end else if (link.addr == ADDR_CTRL1) begin
        rdata_q <= ctrl1_q;
      end else if (link.addr == ADDR_FORMAT) begin
        rdata_q <= format_q;
      end else if (link.addr == ADDR_SHUTDOWN) begin
        rdata_q <= shut_q;
      end else if (link.addr == ADDR_QUIET) begin
        rdata_q <= quiet_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign link.rdata = rdata_q;

  // ****************************************
  // control outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dc_block_en <= 1'b1;
      hard_unmute <= 1'b1;
      deemph_sel <= DEEMPH_NONE;
      audio_format <= RST_FORMAT[3:0];
      all_shutdown <= 1'b1;
      quiet_ch <= 2'b00;
    end else if (clk_en) begin
      dc_block_en <= ctrl1_q[C1_DCBLOCK];
      hard_unmute <= ctrl1_q[C1_HARD_UNMUTE];
      deemph_sel <= ctrl1_q[1:0];
      audio_format <= format_q[3:0];
      all_shutdown <= shut_q[SD_SHUTDOWN];
      quiet_ch <= quiet_q[1:0];
    end
  end
endmodule

// File: rtl/aacs_pkg.sv
// aacs_pkg: register map, field layout, codes and timing of the amplifier control/status bank
// assumes a single 250 MHz reference clock at both ends
// What this block does
// - detect clocks, report rate and ratio fields
// - rate codes: 32,48,16,24,8,12 kHz
// - ratio codes: 64 to 512 times rate
// - source gives bit clock 64/32/48 times rate
// - low ratios only at permitted rates
// - error flags sticky, cleared by writing zero
// - host clears errors, then reads back
// - flag master or bit clock count change
// - flag frame rate change and frame slip
// - bit1 protection fault, bit0 thermal warning
// - control1 bit7 dc-blocking filter, default on
// - control1 bit5 hard unmute, default set
// - control1 bits1..0 select de-emphasis
// - format codes 0..8, default 24-bit I2S
// - control2 bit6 shutdown, default set
// - soft mute bits force 50% duty
// - id register returns fixed seven-bit code
// - host avoids reserved registers and codes; aacs_host drops reserved registers but passes any code
package aacs_pkg;
  localparam logic [7:0] ADDR_CLK_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FW_ID = 8'h01;
  localparam logic [7:0] ADDR_FAULTS = 8'h02;
  localparam logic [7:0] ADDR_CTRL1 = 8'h03;
  localparam logic [7:0] ADDR_FORMAT = 8'h04;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h05;
  localparam logic [7:0] ADDR_QUIET = 8'h06;
  localparam logic [7:0] ADDR_LAST = 8'h06;
  // reset values and write masks
  localparam logic [7:0] RST_FAULTS = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'ha0;
  localparam logic [7:0] RST_FORMAT = 8'h05;
  localparam logic [7:0] RST_SHUTDOWN = 8'h40;
  localparam logic [7:0] RST_QUIET = 8'h00;
  localparam logic [7:0] CTRL1_MASK = 8'ha3;
  localparam logic [7:0] FORMAT_MASK = 8'h0f;
  localparam logic [7:0] SHUTDOWN_MASK = 8'h40;
  localparam logic [7:0] QUIET_MASK = 8'h03;
  // id code: value arbitrary
  localparam logic [6:0] FW_ID_VALUE = 7'h2a;
  // field positions
  localparam int RATE_LSB = 5;
  localparam int RATIO_LSB = 2;
  localparam int ERR_MCLK = 7;
  localparam int ERR_PLL = 6;
  localparam int ERR_SCLK = 5;
  localparam int ERR_LRCLK = 4;
  localparam int ERR_SLIP = 3;
  localparam int ERR_PROT = 1;
  localparam int ERR_OTW = 0;
  localparam int C1_DCBLOCK = 7;
  localparam int C1_HARD_UNMUTE = 5;
  localparam int SD_SHUTDOWN = 6;
  // sample rate codes
  localparam logic [2:0] RATE_32K = 3'h0;
  localparam logic [2:0] RATE_48K = 3'h3;
  localparam logic [2:0] RATE_16K = 3'h4;
  localparam logic [2:0] RATE_24K = 3'h5;
  localparam logic [2:0] RATE_8K = 3'h6;
  localparam logic [2:0] RATE_12K = 3'h7;
  // ratio codes
  localparam logic [2:0] RATIO_64 = 3'h0;
  localparam logic [2:0] RATIO_128 = 3'h1;
  localparam logic [2:0] RATIO_192 = 3'h2;
  localparam logic [2:0] RATIO_256 = 3'h3;
  localparam logic [2:0] RATIO_384 = 3'h4;
  localparam logic [2:0] RATIO_512 = 3'h5;
  localparam logic [2:0] RATIO_BAD = 3'h7;
  // de-emphasis and format
  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_32K = 2'h1;
  localparam logic [1:0] DEEMPH_48K = 2'h3;
  localparam logic [3:0] FMT_LAST = 4'h8;
  // timing: reference clock, frame period limits per rate in reference cycles
  localparam int CLK_MHZ = 250;
  localparam int FRAME_CNT_W = 16;
  localparam int FRAME_TOL = 4;
  // frame period in ns for each rate class (48k family; 44K, 24K and 12K use 44.1k-family periods)
  localparam int FRAME_NS_48K = 20833;
  localparam int FRAME_CYC_48K = FRAME_NS_48K * CLK_MHZ / 1000;
  localparam int FRAME_CYC_44K = 22675 * CLK_MHZ / 1000;
  localparam int FRAME_CYC_32K = 31250 * CLK_MHZ / 1000;
  localparam int FRAME_CYC_24K = 45351 * CLK_MHZ / 1000;
  localparam int FRAME_CYC_16K = 62500 * CLK_MHZ / 1000;
  localparam int FRAME_CYC_12K = 90703 * CLK_MHZ / 1000;
  localparam int FRAME_CYC_8K = 125000 * CLK_MHZ / 1000;
endpackage

// File: rtl/aacs_if.sv
// aacs_if: serial-control register port plus audio clock and status lines between amp and host
// assumes both ends share ref_clk; audio clocks originate at the host side
`timescale 1ns/1ps
interface aacs_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic mclk;
  logic sclk;
  logic lrclk;
  logic prot_fault;
  logic temp_warn;
  modport amp (input addr, input wdata, input wr, input rd, output rdata,
               input mclk, input sclk, input lrclk, input prot_fault, input temp_warn);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
                output mclk, output sclk, output lrclk);
endinterface

// File: rtl/aacs_host.sv
// aacs_host: host controller end; runs register accesses and makes the audio clocks by division
// assumes a user-side command port on ref_clk
`timescale 1ns/1ps
module aacs_host
  import aacs_pkg::*;
#(
  parameter int MCLK_DIV = 10,
  parameter int MCLK_PER_FRAME = 256,
  parameter int SCLK_PER_FRAME = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // link
  aacs_if.host link,
  // user command port
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid
);
  localparam int FRAME_REF_CYC = MCLK_DIV * MCLK_PER_FRAME;
  if (MCLK_DIV < 2 || MCLK_DIV > 512 || MCLK_DIV % 2 != 0) begin : g_bad_div
    $error("aacs_host: MCLK_DIV must be even, 2 to 512");
  end
  if (!(SCLK_PER_FRAME == 64 || SCLK_PER_FRAME == 32 ||
        (SCLK_PER_FRAME == 48 && (MCLK_PER_FRAME == 192 || MCLK_PER_FRAME == 384)))) begin : g_bad_sclk
    $error("aacs_host: bit clock ratio not allowed");
  end else if (MCLK_PER_FRAME % SCLK_PER_FRAME != 0 || MCLK_PER_FRAME / SCLK_PER_FRAME < 2) begin : g_bad_split
    $error("aacs_host: bit clock must divide master clock by two or more");
  end
  if ((MCLK_PER_FRAME != 64 && MCLK_PER_FRAME != 128 && MCLK_PER_FRAME != 192 &&
       MCLK_PER_FRAME != 256 && MCLK_PER_FRAME != 384 && MCLK_PER_FRAME != 512) ||
      (MCLK_PER_FRAME <= 128 && FRAME_REF_CYC >= (FRAME_CYC_48K + FRAME_CYC_32K) / 2) ||
      (MCLK_PER_FRAME == 192 && FRAME_REF_CYC >= (FRAME_CYC_32K + FRAME_CYC_24K) / 2) ||
      (MCLK_PER_FRAME == 256 && FRAME_REF_CYC >= (FRAME_CYC_12K + FRAME_CYC_8K) / 2)) begin : g_bad_rate
    $error("aacs_host: master clock ratio not allowed at this rate");
  end

  // ****************************************
  // audio clock divider
  // ****************************************
  logic [7:0] div_q;
  logic [9:0] mcnt_q;
  logic mclk_q, sclk_q, lr_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 8'h00;
      mcnt_q <= 10'h000;
      mclk_q <= 1'b0;
      sclk_q <= 1'b0;
      lr_q <= 1'b0;
    end else if (clk_en) begin
      if (div_q == 8'(MCLK_DIV / 2 - 1)) begin
        div_q <= 8'h00;
        mclk_q <= ~mclk_q;
        if (mclk_q) begin
          mcnt_q <= (mcnt_q == 10'(MCLK_PER_FRAME - 1)) ? 10'h000 : mcnt_q + 10'h001;
          sclk_q <= (mcnt_q % 10'(MCLK_PER_FRAME / SCLK_PER_FRAME)) <
                    10'(MCLK_PER_FRAME / SCLK_PER_FRAME / 2) ? 1'b0 : 1'b1;
          lr_q <= mcnt_q >= 10'(MCLK_PER_FRAME / 2);
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end
  assign link.mclk = mclk_q;
  assign link.sclk = sclk_q;
  assign link.lrclk = lr_q;

  // ****************************************
  // register access: are the caller's order
  // ****************************************
  logic [7:0] addr_q, wdata_q;
  logic wr_q, rd_q, rd_any_q, rd_d1_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_any_q <= 1'b0;
      rd_d1_q <= 1'b0;
      cmd_rdata <= 8'h00;
      cmd_rvalid <= 1'b0;
    end else if (clk_en) begin
      wr_q <= cmd_wr && cmd_addr <= ADDR_LAST;
      rd_q <= cmd_rd && !cmd_wr && cmd_addr <= ADDR_LAST;
      rd_any_q <= cmd_rd && !cmd_wr;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
      // a reserved read skips the link and returns the idle zero of rdata
      rd_d1_q <= rd_any_q;
      cmd_rvalid <= rd_d1_q;
      if (rd_d1_q) cmd_rdata <= link.rdata;
    end
  end
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr = wr_q;
  assign link.rd = rd_q;
endmodule

// File: verification/aacs_sva.sv
// aacs_sva: register-port checks on the link between amp and host
// assumes instantiation beside the link, its signals passed as plain inputs
`timescale 1ns/1ps
module aacs_sva
  import aacs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic prot_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ****************
  // helper state
  // ****************
  logic [3:0] hi_q;
  logic rd_f_q;
  logic seen_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_q <= 4'h0;
    end else if (!prot_fault) begin
      hi_q <= 4'h0;
    end else if (hi_q != 4'hf) begin
      hi_q <= hi_q + 4'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_f_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      rd_f_q <= rd && addr == ADDR_FAULTS;
      if (wr && addr == ADDR_FAULTS && !wdata[ERR_PROT]) begin
        seen_q <= 1'b0;
      end else if (rd_f_q && rdata[ERR_PROT]) begin
        seen_q <= 1'b1;
      end
    end
  end
  // ****************
  // properties
  // ****************
  property p_id; rd && addr == ADDR_FW_ID |=> rdata[6:0] == FW_ID_VALUE; endproperty
  a_id: assert property (p_id) else $error("id code wrong");
  property p_ctrl1_wr; wr && addr == ADDR_CTRL1 ##1 rd && addr == ADDR_CTRL1 |=> rdata == ($past(wdata, 2) & CTRL1_MASK);
  endproperty
  a_ctrl1_wr: assert property (p_ctrl1_wr) else $error("control1 readback wrong");
  property p_fmt; rd && addr == ADDR_FORMAT |=> rdata[7:4] == 4'h0; endproperty
  a_fmt: assert property (p_fmt) else $error("format upper bits set");
  property p_sd; rd && addr == ADDR_SHUTDOWN |=> (rdata & 8'hbf) == 8'h00; endproperty
  a_sd: assert property (p_sd) else $error("shutdown reserved bits set");
  property p_quiet; wr && addr == ADDR_QUIET ##1 rd && addr == ADDR_QUIET |=> rdata == ($past(wdata, 2) & QUIET_MASK);
  endproperty
  a_quiet: assert property (p_quiet) else $error("mute readback wrong");
  property p_unmapped; rd || wr |-> addr <= ADDR_LAST; endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved register accessed");
  property p_prot; rd && addr == ADDR_FAULTS && hi_q == 4'hf |=> rdata[ERR_PROT]; endproperty
  a_prot: assert property (p_prot) else $error("protection flag missing");
  property p_sticky; rd && addr == ADDR_FAULTS && seen_q |=> rdata[ERR_PROT]; endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared without write");
endmodule

// File: verification/audio_amp_control_status_regs_tb.sv
// audio_amp_control_status_regs_tb: host and amp joined by the link, driven from the host command port
// assumes design files compiled first
`timescale 1ns/1ps
module audio_amp_control_status_regs_tb
  import aacs_pkg::*;
  ;
  logic ref_clk, nrst, host_en, cmd_wr, cmd_rd, cmd_rvalid, dc_block_en, hard_unmute, all_shutdown, pll_locked;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, v;
  logic [3:0] audio_format;
  logic [2:0] sample_frequency, mclk_ratio;
  logic [1:0] deemph_sel, quiet_ch;
  logic [31:0] lfsr_q;
  logic amp_en;
  logic [7:0] rst_tab [5] = '{RST_FAULTS, RST_CTRL1, RST_FORMAT, RST_SHUTDOWN, RST_QUIET};
  int mismatches = 0;
  int checks = 0;
  aacs_if link ();
  aacs_amp i_aacs_amp (.ref_clk(ref_clk), .nrst(nrst), .clk_en(amp_en), .link(link.amp), .dc_block_en(dc_block_en),
    .hard_unmute(hard_unmute), .deemph_sel(deemph_sel), .audio_format(audio_format), .all_shutdown(all_shutdown),
    .quiet_ch(quiet_ch), .sample_frequency(sample_frequency), .mclk_ratio(mclk_ratio), .pll_locked(pll_locked));
  aacs_host #(.MCLK_DIV(10), .MCLK_PER_FRAME(512), .SCLK_PER_FRAME(64)) i_aacs_host (.ref_clk(ref_clk), .nrst(nrst),
    .clk_en(host_en), .link(link.host), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
  aacs_sva i_aacs_sva (.ref_clk(ref_clk), .nrst(nrst), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
    .rd(link.rd), .rdata(link.rdata), .prot_fault(link.prot_fault));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    int n;
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    n = 0;
    while (cmd_rvalid !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 8) begin
      mismatches++;
      test_done();
    end else begin
      check(cmd_rdata & m, e & m);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    reg_rd(a, d, 8'hff);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    nrst = 1'b0;
    host_en = 1'b1;
    amp_en = 1'b1;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    link.prot_fault = 1'b0;
    link.temp_warn = 1'b0;
    lfsr_q = 32'h00013a95;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check({dc_block_en, hard_unmute, deemph_sel, all_shutdown, quiet_ch, 1'b0}, 8'hc8);
    check({4'h0, audio_format}, 8'h05);
    for (int i = 0; i < 5; i++) reg_rd(8'(i + 2), rst_tab[i], 8'hff);
    reg_wr(ADDR_FW_ID, 8'h55);
    reg_rd(ADDR_FW_ID, {1'b0, FW_ID_VALUE}, 8'h7f);
    reg_wr(ADDR_CLK_STATUS, 8'h00);
    reg_rd(8'h07, 8'h00, 8'hff);
    reg_rd(8'hff, 8'h00, 8'hff);
    $display("register map test done");
    for (int i = 0; i < 9; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      v = {lfsr_q[7], 1'b0, lfsr_q[5], 3'h0, (i % 3 == 2) ? 2'h3 : 2'(i % 3)};
      wr_rd(ADDR_CTRL1, v);
      check({dc_block_en, hard_unmute, deemph_sel, 4'h0}, {v[7], v[5], v[1:0], 4'h0});
      wr_rd(ADDR_FORMAT, 8'(i));
      check({4'h0, audio_format}, 8'(i));
      wr_rd(ADDR_SHUTDOWN, {1'b0, lfsr_q[12], 6'h00});
      check({7'h00, all_shutdown}, {7'h00, lfsr_q[12]});
      wr_rd(ADDR_QUIET, {6'h00, lfsr_q[14:13]});
      check({6'h00, quiet_ch}, {6'h00, lfsr_q[14:13]});
    end
    $display("random control test done");
    repeat (30720) @(posedge ref_clk);
    reg_rd(ADDR_CLK_STATUS, {RATE_48K, RATIO_512, 2'h0}, 8'hfc);
    check({pll_locked, sample_frequency, 1'b0, mclk_ratio}, {1'b1, 3'h3, 1'b0, 3'h5});
    $display("clock detect test done");
    reg_wr(ADDR_FAULTS, 8'h00);
    reg_rd(ADDR_FAULTS, 8'h00, 8'hff);
    link.prot_fault <= 1'b1;
    link.temp_warn <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reg_rd(ADDR_FAULTS, 8'h03, 8'hff);
    link.prot_fault <= 1'b0;
    link.temp_warn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reg_wr(ADDR_FAULTS, 8'hff);
    reg_rd(ADDR_FAULTS, 8'h03, 8'hff);
    reg_wr(ADDR_FAULTS, 8'h00);
    reg_rd(ADDR_FAULTS, 8'h00, 8'hff);
    $display("fault flag test done");
    // freezing the amp drops clock edges and shortens one frame
    amp_en <= 1'b0;
    repeat (200) @(posedge ref_clk);
    amp_en <= 1'b1;
    repeat (20480) @(posedge ref_clk);
    reg_rd(ADDR_FAULTS, 8'he8, 8'hf8);
    reg_rd(ADDR_FAULTS, 8'h40, 8'h40);
    check({5'h00, mclk_ratio}, {5'h00, RATIO_512});
    reg_wr(ADDR_FAULTS, 8'h00);
    reg_rd(ADDR_FAULTS, 8'h00, 8'hff);
    host_en <= 1'b0;
    repeat (100) @(posedge ref_clk);
    host_en <= 1'b1;
    repeat (20480) @(posedge ref_clk);
    reg_rd(ADDR_FAULTS, 8'h08, 8'h08);
    $display("clock error test done");
    test_done();
  end
endmodule
